// ### adc_ddr_sample_output.sv
// Purpose: digital back end of a 14-bit pipelined converter with DDR out
// Assumes: i_clk models the sample clock; one i_clk cycle per half cycle
// Notes: samples arrive as signed results wider than the output word
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - a sample is taken on each tick of the sample clock with i_sample_valid high while the block is in run.
// - each sample leaves the pipeline 3.5 sample periods after capture.
// - every sample leaves as one 14-bit offset binary word.
// - bit 13 of the word is the top line and bit 0 the bottom line.
// - the ready strobe toggles once per word, forming a half-rate DDR link.
// - the ready strobe is the sample clock divided by two only while every tick brings a sample.
// - the strobe divider has no defined start phase after power-down.
// - the over-range flag is high when the result leaves the word range.
// - strobe, word and flag all change on the update tick together.
// - power-down holds the block idle; it resumes 5 us after release.
module adc_ddr_sample_output #(
    parameter int unsigned wake_count = adc_out_pkg::wake_cycles
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sample_valid,
    input wire logic signed [15:0] i_sample,
    input wire logic i_power_down_input,
    output logic [13:0] o_sample_word,
    output logic o_over_range_flag,
    output logic o_ready_strobe,
    output logic o_powered
);
    localparam int unsigned lat = adc_out_pkg::latency_half_cycles;
    // buffer and output flop take the last two half cycles of the latency
    localparam int unsigned depth = lat - 2;

    typedef struct packed {
        logic [2:0] pd_sync;
        logic pd_level;
        adc_out_pkg::power_state_t pwr;
        logic [31:0] wake_cnt;
        logic [depth-1:0] pipe_valid;
        logic [depth-1:0][14:0] pipe_data;
        logic [13:0] word;
        logic over_range;
        logic strobe;
        logic powered;
    } core_state_t;

    core_state_t state;
    core_state_t next_state;
    logic running;
    logic [13:0] coded;
    logic clipped;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [14:0] buf_out_data;
    adc_out_pkg::sample_t in_sample;
    adc_out_pkg::sample_t out_sample;

    // stage inputs, one entry per pipeline stage
    logic [depth-1:0] shift_valid;
    logic [depth-1:0][14:0] shift_data;
    logic buf_flush;

    // results outside the word saturate; only the flag tells them apart
    // clip and convert two's complement into offset binary
    always_comb
    begin
        clipped = 1'b0;
        coded = adc_out_pkg::code_mid_scale;
        if (i_sample < adc_out_pkg::signed_min)
        begin
            clipped = 1'b1;
            coded = adc_out_pkg::code_all_zero;
        end
        else if (i_sample > adc_out_pkg::signed_max)
        begin
            clipped = 1'b1;
            coded = adc_out_pkg::code_all_one;
        end
        else
        begin
            coded = {~i_sample[13], i_sample[12:0]};
        end
        in_sample.word = coded;
        in_sample.over_range = clipped;
    end

    assign running = (state.pwr == adc_out_pkg::st_run);

    // a word caught in the buffer at power-down must not leak out on wake
    assign buf_flush = i_rst || !running;

    // stage g takes stage g-1; stage 0 takes the freshly coded sample
    assign shift_valid[0] = i_sample_valid;
    assign shift_data[0] = in_sample;
    for (genvar g = 1; g < depth; g++)
    begin : g_stage
        assign shift_valid[g] = state.pipe_valid[g - 1];
        assign shift_data[g] = state.pipe_data[g - 1];
    end

    always_comb
    begin
        next_state = state;
        // only the second and third stages are compared
        next_state.pd_sync = {state.pd_sync[1:0], i_power_down_input};
        if (state.pd_sync[2] == state.pd_sync[1])
        begin
            next_state.pd_level = state.pd_sync[2];
        end
        case (state.pwr)
            adc_out_pkg::st_down:
            begin
                next_state.powered = 1'b0;
                if (!state.pd_level)
                begin
                    next_state.pwr = adc_out_pkg::st_waking;
                    next_state.wake_cnt = '0;
                end
            end
            adc_out_pkg::st_waking:
            begin
                // a pd pulse during wake-up restarts the full wait
                if (state.pd_level)
                begin
                    next_state.pwr = adc_out_pkg::st_down;
                end
                else if (state.wake_cnt == 32'(wake_count - 1))
                begin
                    next_state.pwr = adc_out_pkg::st_run;
                    next_state.powered = 1'b1;
                end
                else
                begin
                    next_state.wake_cnt = state.wake_cnt + 32'd1;
                end
            end
            adc_out_pkg::st_run:
            begin
                // pipe and buffer are flushed once running drops
                if (state.pd_level)
                begin
                    next_state.pwr = adc_out_pkg::st_down;
                    next_state.powered = 1'b0;
                end
            end
            default:
            begin
                next_state.pwr = adc_out_pkg::st_down;
                next_state.powered = 1'b0;
            end
        endcase
        // half-cycle pipeline; a stall holds every stage in place
        if (!running)
        begin
            next_state.pipe_valid = '0;
        end
        else if (buf_in_ready)
        begin
            next_state.pipe_valid = shift_valid;
            next_state.pipe_data = shift_data;
        end
        // strobe phase is kept across power-down, not reset to a value
        if (running && buf_out_valid)
        begin
            out_sample = buf_out_data;
            next_state.word = out_sample.word;
            next_state.over_range = out_sample.over_range;
            next_state.strobe = ~state.strobe;
        end
        else
        begin
            out_sample = '0;
        end
    end

    // in run the buffer holds at most one word, so the pipe never stalls
    sample_skid_buffer #(
        .width(15)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst(buf_flush),
        .i_valid(running && state.pipe_valid[depth-1]),
        .o_ready(buf_in_ready),
        .i_data(state.pipe_data[depth-1]),
        .o_valid(buf_out_valid),
        .i_ready(running),
        .o_data(buf_out_data)
    );

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            // pd held high at reset so wake-up runs from a known state
            state.pd_sync <= 3'h7;
            state.pd_level <= 1'b1;
            state.pwr <= adc_out_pkg::st_down;
            state.wake_cnt <= '0;
            state.pipe_valid <= '0;
            state.pipe_data <= '0;
            state.word <= '0;
            state.over_range <= 1'b0;
            state.strobe <= 1'b0;
            state.powered <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // every output is a state flop with no logic after it
    assign o_sample_word = state.word;
    assign o_over_range_flag = state.over_range;
    assign o_ready_strobe = state.strobe;
    assign o_powered = state.powered;
endmodule // adc_ddr_sample_output
`default_nettype wire

// ### adc_out_pkg.sv
// Purpose: shared constants and carriers for the sample output path
// Assumes: one system clock standing in for the sample clock, 250 MHz
// Notes: widths in bits, latency counts in half-cycle units
`default_nettype none
package adc_out_pkg;
    localparam int unsigned word_width = 14;
    // latency 3.5 cycles expressed in half cycles
    localparam int unsigned latency_half_cycles = 7;
    localparam int unsigned clk_period_ps = 4000;
    localparam int unsigned wake_time_us = 5;
    localparam int unsigned wake_cycles =
        (wake_time_us * 1000000) / clk_period_ps;
    localparam logic [13:0] code_all_zero = 14'h0000;
    localparam logic [13:0] code_all_one = 14'h3fff;
    localparam logic [13:0] code_mid_scale = 14'h2000;
    localparam logic signed [15:0] signed_min = -16'sh2000;
    localparam logic signed [15:0] signed_max = 16'sh1fff;

    typedef struct packed {
        logic [13:0] word;
        logic over_range;
    } sample_t;

    typedef enum logic [1:0] {
        st_down,
        st_waking,
        st_run
    } power_state_t;
endpackage
`default_nettype wire

// ### sample_skid_buffer.sv
// Purpose: two-entry buffer between the pipeline and the output stage
// Assumes: producer and consumer on the same clock
// Notes: full drop of ready only when both entries hold words
`timescale 1ns/10ps
`default_nettype none
module sample_skid_buffer #(
    parameter int unsigned width = 15
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [width-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [width-1:0] o_data
);
    typedef struct packed {
        logic [1:0][width-1:0] mem;
        logic [1:0] count;
        logic rd_ptr;
        logic wr_ptr;
    } skid_state_t;

    skid_state_t state;
    skid_state_t next_state;
    logic push;
    logic pop;

    always_comb
    begin
        push = i_valid && (state.count != 2'd2);
        pop = (state.count != 2'd0) && i_ready;
        next_state = state;
        if (push)
        begin
            next_state.mem[state.wr_ptr] = i_data;
            next_state.wr_ptr = ~state.wr_ptr;
        end
        if (pop)
        begin
            next_state.rd_ptr = ~state.rd_ptr;
        end
        next_state.count = state.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_ready = (state.count != 2'd2);
    assign o_valid = (state.count != 2'd0);
    assign o_data = state.mem[state.rd_ptr];
endmodule // sample_skid_buffer
`default_nettype wire

// ### adc_rx_model.sv
// Purpose: receiver model for the ddr sample link
// Assumes: runs on the sample clock
// Notes: keeps up to 16 words
`timescale 1ns/10ps
`default_nettype none
module adc_rx_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_strobe,
    input wire logic [13:0] i_word,
    input wire logic i_flag
);
    logic last;
    logic [4:0] cnt;
    logic [14:0] cap [16];
    // one edge late for setup; any strobe direction, phase unknown
    always_ff @(posedge i_clk)
    begin
        last <= i_strobe;
        if (i_rst)
            cnt <= 5'd0;
        else if (i_strobe != last)
        begin
            cap[cnt[3:0]] <= {i_flag, i_word};
            cnt <= cnt + 5'd1;
        end
    end
endmodule // adc_rx_model
`default_nettype wire

// ### adc_ddr_sample_output_checker.sv
// Purpose: port checks of the sample output block
// Assumes: one clock, sync reset
// Notes: word lands 7 cycles after take
`timescale 1ns/10ps
`default_nettype none
module adc_ddr_sample_output_checker #(
    parameter int unsigned wake_count = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sample_valid,
    input wire logic signed [15:0] i_sample,
    input wire logic i_power_down_input,
    input wire logic [13:0] o_sample_word,
    input wire logic o_over_range_flag,
    input wire logic o_ready_strobe,
    input wire logic o_powered
);
    logic take;
    logic inr;
    assign take = i_sample_valid && o_powered;
    assign inr = i_sample >= adc_out_pkg::signed_min &&
        i_sample <= adc_out_pkg::signed_max;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_word_latency: assert property (
        take |-> ##7 $changed(o_ready_strobe))
        else $error("word late");
    a_offset_code: assert property (
        take && inr |-> ##7 o_sample_word ==
        {~$past(i_sample[13], 7), $past(i_sample[12:0], 7)})
        else $error("bad code");
    a_clip_low: assert property (
        take && i_sample < adc_out_pkg::signed_min |-> ##7
        o_sample_word == 14'h0000 && o_over_range_flag)
        else $error("low clip");
    a_clip_high: assert property (
        take && i_sample > adc_out_pkg::signed_max |-> ##7
        o_sample_word == 14'h3fff && o_over_range_flag)
        else $error("high clip");
    a_flag_clear: assert property (
        take && inr |-> ##7 !o_over_range_flag)
        else $error("flag set");
    a_word_strobe: assert property (
        $changed(o_sample_word) |-> $changed(o_ready_strobe))
        else $error("word without strobe");
    a_idle_still: assert property (
        !$past(take, 7) |-> $stable(o_ready_strobe) &&
        $stable(o_sample_word))
        else $error("idle change");
    a_wake_time: assert property (
        $rose(o_powered) |-> !$past(i_power_down_input, wake_count))
        else $error("woke early");
    a_down_off: assert property (
        i_power_down_input [*6] |-> !o_powered)
        else $error("still powered");
    a_strobe_half: assert property (
        $changed(o_ready_strobe) |=> $stable(o_ready_strobe))
        else $error("strobe too fast");
endmodule // adc_ddr_sample_output_checker
bind adc_ddr_sample_output adc_ddr_sample_output_checker #(
    .wake_count(wake_count)
) chk (.i_clk(i_clk), .i_rst(i_rst), .i_sample_valid(i_sample_valid),
    .i_sample(i_sample), .i_power_down_input(i_power_down_input),
    .o_sample_word(o_sample_word), .o_over_range_flag(o_over_range_flag),
    .o_ready_strobe(o_ready_strobe), .o_powered(o_powered));
`default_nettype wire

// ### adc_ddr_sample_output_test.sv
// Purpose: self-checking bench of the sample output block
// Assumes: inputs driven on the falling edge
// Notes: wake_count cut to 8 for a short run
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) num_checks++; if ((a) !== (b)) \
    begin \
        error_cnt++; $display("Error %0t %h %h", $time, (a), (b)); \
    end
module adc_ddr_sample_output_test;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_sample_valid = 1'b0;
    logic signed [15:0] i_sample = 16'sh0000;
    logic i_power_down_input = 1'b0;
    logic [13:0] o_sample_word;
    logic o_over_range_flag;
    logic o_ready_strobe;
    logic o_powered;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    logic signed [15:0] stim [9] = '{16'she000, 16'sh1fff, 16'sh0000,
        16'shffff, 16'sh0001, 16'shdcd8, 16'sh2328, 16'sh7fff, 16'sh8000};
    logic [14:0] expv [9] = '{15'h0000, 15'h3fff, 15'h2000, 15'h1fff,
        15'h2001, 15'h4000, 15'h7fff, 15'h7fff, 15'h4000};
    adc_ddr_sample_output #(.wake_count(8)) DUT (.i_clk(i_clk),
        .i_rst(i_rst), .i_sample_valid(i_sample_valid),
        .i_sample(i_sample), .i_power_down_input(i_power_down_input),
        .o_sample_word(o_sample_word), .o_over_range_flag(o_over_range_flag),
        .o_ready_strobe(o_ready_strobe), .o_powered(o_powered));
    adc_rx_model rx (.i_clk(i_clk), .i_rst(i_rst), .i_strobe(o_ready_strobe),
        .i_word(o_sample_word), .i_flag(o_over_range_flag));
    initial
    begin
        forever #2 i_clk = ~i_clk;
    end
    task end_sim;
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one row per sample period, then enough idle for the pipe to drain
    task send(input int a, input int b);
        for (int i = a; i <= b; i++)
        begin
            @(negedge i_clk);
            i_sample_valid = 1'b1;
            i_sample = stim[i];
            @(negedge i_clk);
            i_sample_valid = 1'b0;
        end
        repeat (12) @(negedge i_clk);
    endtask
    task wait_up;
        n = 0;
        while (o_powered !== 1'b1 && n < 60)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHK(n >= 8 && n < 60, 1'b1)
    endtask
    initial
    begin
        #8000;
        error_cnt++;
        end_sim;
    end
    initial
    begin
        repeat (5) @(negedge i_clk);
        `CHK({o_sample_word, o_over_range_flag, o_ready_strobe}, 16'h0)
        i_rst = 1'b0;
        wait_up;
        send(0, 8);
        `CHK(rx.cnt, 5'd9)
        for (int i = 0; i < 9; i++)
        begin
            `CHK(rx.cap[i], expv[i])
        end
        i_power_down_input = 1'b1;
        repeat (6) @(negedge i_clk);
        send(0, 8);
        `CHK({o_powered, rx.cnt}, 6'd9)
        i_power_down_input = 1'b0;
        wait_up;
        send(6, 6);
        `CHK(rx.cap[9], expv[6])
        i_sample_valid = 1'b1;
        i_rst = 1'b1;
        repeat (5) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        `CHK({o_powered, o_ready_strobe, rx.cnt}, 7'd0)
        i_sample_valid = 1'b0;
        wait_up;
        end_sim;
    end
endmodule // adc_ddr_sample_output_test
`default_nettype wire
